// ---- pkg/ebrg_pkg.sv ----
// Package for the external bus request/grant block: states and constants.
// Assumes a single 125 MHz clock domain; no software-visible registers.
package ebrg_pkg;

	localparam int unsigned CLK_PERIOD_NS = 8;
	// Longest external access including wait states, in cycles
	localparam int unsigned MAX_ACCESS_CYCLES = 8;
	localparam logic [3:0]  WAIT_CNT_W0       = 4'h0;
	localparam logic [3:0]  WAIT_CNT_MAX      = 4'h7;
	// Active-low levels on the request and grant pins
	localparam logic        PIN_ASSERTED      = 1'b0;
	localparam logic        PIN_IDLE          = 1'b1;
	localparam logic [1:0]  SYNC_RESET        = 2'h3;

	typedef enum logic [3:0] {
		EBRG_OWN     = 4'h1,
		EBRG_ACCESS  = 4'h2,
		EBRG_GRANTED = 4'h4,
		EBRG_RETURN  = 4'h8
	} ebrg_state_type;

endpackage : ebrg_pkg

// ---- logic/ebrg_sync.sv ----
// Two-stage synchroniser for one level, with a constant reset value.
// Assumes the destination clock is clk; first stage feeds only the second.
`timescale 1ns/1ns
module ebrg_sync #(
	parameter logic RESET_VALUE = 1'b1
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Level crossing
	input  wire logic din,
	output logic      dout
);

	logic meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RESET_VALUE;
			dout   <= RESET_VALUE;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end

endmodule : ebrg_sync

// ---- logic/ebrg_arbiter.sv ----
// External bus request/grant arbiter of the processor memory interface.
// Assumes the core reports access start/end, boot byte progress and stall needs;
// the pad ring combines the output enables with the bus drivers.
`timescale 1ns/1ns
module ebrg_arbiter (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Variant and mode straps
	input  wire logic old_revision,
	input  wire logic continue_mode,
	// Processor reset and boot status
	input  wire logic core_reset_active,
	input  wire logic boot_active,
	input  wire logic boot_byte_done,
	// Core memory access status
	input  wire logic access_start,
	input  wire logic access_done,
	input  wire logic access_needed,
	// External master
	input  wire logic bus_request_n,
	output logic      bus_grant_n,
	// Bus driver enables, low while driving
	output logic      addr_oe_n,
	output logic      data_oe_n,
	output logic      program_memory_select_oe_n,
	output logic      data_memory_select_oe_n,
	output logic      boot_memory_select_oe_n,
	output logic      read_strobe_oe_n,
	output logic      write_strobe_oe_n,
	// Core control
	output logic      core_halt
);

	typedef struct packed {
		ebrg_pkg::ebrg_state_type state;
		logic                    in_access;
		logic                    boot_byte_open;
		logic                    grant_n;
		logic                    addr_oe_n;
		logic                    data_oe_n;
		logic                    program_memory_select_oe_n;
		logic                    data_memory_select_oe_n;
		logic                    boot_memory_select_oe_n;
		logic                    read_strobe_oe_n;
		logic                    write_strobe_oe_n;
		logic                    halt;
	} ebrg_regs_type;

	ebrg_regs_type r_q;
	ebrg_regs_type r_d;
	// Reset copy kept apart: it must not be cleared by the reset it makes
	logic [1:0]    rst_sync_q;
	logic          rst_n_int;
	logic          req_sync;
	logic          req_seen;
	logic          access_block;
	logic          byte_block;
	logic          may_grant;
	logic          float_req;

	assign rst_n_int = rst_sync_q[1];

	// Newer variant samples the pin through two flops
	ebrg_sync #(
		.RESET_VALUE (ebrg_pkg::PIN_IDLE)
	) u_req_sync (
		.clk   (clk),
		.rst_n (rst_n_int),
		.din   (bus_request_n),
		.dout  (req_sync)
	);

	always_comb begin
		// Old variant takes the pin as already synchronous
		req_seen = old_revision ? (bus_request_n == ebrg_pkg::PIN_ASSERTED)
		                        : (req_sync == ebrg_pkg::PIN_ASSERTED);
		// Done cycle already frees the bus, so grant lands the cycle after
		access_block = r_q.in_access && !access_done;
		byte_block   = boot_active && r_q.boot_byte_open && !boot_byte_done;
		// A starting access wins over a grant in the same cycle
		may_grant = !access_start && !access_block && !byte_block;
	end

	always_comb begin
		r_d       = r_q;
		float_req = r_q.addr_oe_n;
		// Access tracking; a start in the done cycle opens a new access
		if (access_start)
			r_d.in_access = 1'b1;
		else if (access_done)
			r_d.in_access = 1'b0;
		if (boot_active && access_start)
			r_d.boot_byte_open = 1'b1;
		else if (boot_byte_done || !boot_active)
			r_d.boot_byte_open = 1'b0;
		unique case (r_q.state)
			ebrg_pkg::EBRG_OWN: begin
				if (req_seen && !may_grant) begin
					r_d.state = ebrg_pkg::EBRG_ACCESS;
				end else if (req_seen) begin
					// Float, grant and halt together; no halt in continue mode unless the core needs the bus
					r_d.state   = ebrg_pkg::EBRG_GRANTED;
					r_d.grant_n = ebrg_pkg::PIN_ASSERTED;
					float_req   = 1'b1;
					r_d.halt    = !continue_mode || access_needed;
				end
			end
			ebrg_pkg::EBRG_ACCESS: begin
				// Keep driving until the access ends, grant the cycle after
				if (!req_seen) begin
					r_d.state = ebrg_pkg::EBRG_OWN;
				end else if (may_grant) begin
					r_d.state   = ebrg_pkg::EBRG_GRANTED;
					r_d.grant_n = ebrg_pkg::PIN_ASSERTED;
					float_req   = 1'b1;
					r_d.halt    = !continue_mode || access_needed;
				end
			end
			ebrg_pkg::EBRG_GRANTED: begin
				if (!req_seen) begin
					// Release grant and redrive; core resumes where stalled
					r_d.state   = ebrg_pkg::EBRG_RETURN;
					r_d.grant_n = ebrg_pkg::PIN_IDLE;
					float_req   = 1'b0;
					r_d.halt    = 1'b0;
				end else if (!continue_mode || access_needed) begin
					// Stall is sticky: the core waits on it until release
					r_d.halt = 1'b1;
				end
			end
			ebrg_pkg::EBRG_RETURN: begin
				// One owned cycle so a fresh request restarts cleanly
				r_d.state = ebrg_pkg::EBRG_OWN;
			end
			default: begin
				r_d.state   = ebrg_pkg::EBRG_OWN;
				r_d.grant_n = ebrg_pkg::PIN_IDLE;
				float_req   = 1'b0;
				r_d.halt    = 1'b0;
			end
		endcase
		// One flop per enable, so the pads see no gate behind the register
		r_d.addr_oe_n                  = float_req;
		r_d.data_oe_n                  = float_req;
		r_d.program_memory_select_oe_n = float_req;
		r_d.data_memory_select_oe_n    = float_req;
		r_d.boot_memory_select_oe_n    = float_req;
		r_d.read_strobe_oe_n           = float_req;
		r_d.write_strobe_oe_n          = float_req;
		// Core reset clears access tracking, except while granted
		if (core_reset_active && r_q.state != ebrg_pkg::EBRG_GRANTED)
			r_d.in_access = 1'b0;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	always_ff @(posedge clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			r_q.state          <= ebrg_pkg::EBRG_OWN;
			r_q.in_access      <= 1'b0;
			r_q.boot_byte_open <= 1'b0;
			r_q.grant_n        <= ebrg_pkg::PIN_IDLE;
			// Drivers are enabled through reset, and any grant is withdrawn
			r_q.addr_oe_n                  <= 1'b0;
			r_q.data_oe_n                  <= 1'b0;
			r_q.program_memory_select_oe_n <= 1'b0;
			r_q.data_memory_select_oe_n    <= 1'b0;
			r_q.boot_memory_select_oe_n    <= 1'b0;
			r_q.read_strobe_oe_n           <= 1'b0;
			r_q.write_strobe_oe_n          <= 1'b0;
			r_q.halt           <= 1'b0;
		end else begin
			r_q.state          <= r_d.state;
			r_q.in_access      <= r_d.in_access;
			r_q.boot_byte_open <= r_d.boot_byte_open;
			r_q.grant_n        <= r_d.grant_n;
			r_q.addr_oe_n                  <= r_d.addr_oe_n;
			r_q.data_oe_n                  <= r_d.data_oe_n;
			r_q.program_memory_select_oe_n <= r_d.program_memory_select_oe_n;
			r_q.data_memory_select_oe_n    <= r_d.data_memory_select_oe_n;
			r_q.boot_memory_select_oe_n    <= r_d.boot_memory_select_oe_n;
			r_q.read_strobe_oe_n           <= r_d.read_strobe_oe_n;
			r_q.write_strobe_oe_n          <= r_d.write_strobe_oe_n;
			r_q.halt           <= r_d.halt;
		end
	end

	// Enables are high (floating) while granted; all straight from flops
	assign bus_grant_n                = r_q.grant_n;
	assign addr_oe_n                  = r_q.addr_oe_n;
	assign data_oe_n                  = r_q.data_oe_n;
	assign program_memory_select_oe_n = r_q.program_memory_select_oe_n;
	assign data_memory_select_oe_n    = r_q.data_memory_select_oe_n;
	assign boot_memory_select_oe_n    = r_q.boot_memory_select_oe_n;
	assign read_strobe_oe_n           = r_q.read_strobe_oe_n;
	assign write_strobe_oe_n          = r_q.write_strobe_oe_n;
	assign core_halt                  = r_q.halt;

endmodule : ebrg_arbiter

// ---- sim/ebrg_properties.sv ----
// Checker on the arbiter pins, bound to ebrg_arbiter below.
// Assumes a request is held until answered and straps stay put meanwhile.
`timescale 1ns/1ns
module ebrg_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Straps and core status
	input wire logic old_revision,
	input wire logic continue_mode,
	input wire logic boot_active,
	input wire logic boot_byte_done,
	input wire logic access_start,
	input wire logic access_done,
	input wire logic access_needed,
	// Pins
	input wire logic bus_request_n,
	input wire logic bus_grant_n,
	input wire logic addr_oe_n,
	input wire logic data_oe_n,
	input wire logic core_halt
);
	logic open_q;
	wire  fin = boot_active ? boot_byte_done : access_done;
	// Open from start to the end of the access or boot byte
	always_ff @(posedge clk or negedge rstn)
		if (!rstn) open_q <= 1'b0;
		else open_q <= access_start | (open_q & ~fin);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence free_req;
		!bus_request_n && bus_grant_n && !open_q && !access_start;
	endsequence
	sequence wait_sync;
		bus_grant_n [*2];
	endsequence
	sequence run_free;
		$past(continue_mode) && !$past(access_needed) && !$past(core_halt);
	endsequence
	AST_GRANT_OLD: assert property (old_revision && $past(bus_grant_n, 2) ##0 free_req |=> !bus_grant_n)
		else $error("old grant late");
	AST_GRANT_NEW: assert property (!old_revision ##0 $fell(bus_request_n) ##0 free_req |-> ##1 wait_sync ##1 !bus_grant_n)
		else $error("new grant timing");
	AST_HOLD_ACCESS: assert property ((access_start || open_q && !fin) && bus_grant_n |=> bus_grant_n && !addr_oe_n)
		else $error("grant inside access");
	AST_FLOAT: assert property (bus_grant_n != addr_oe_n && data_oe_n == addr_oe_n)
		else $error("drivers disagree with grant");
	AST_HALT: assert property (!bus_grant_n && !$past(continue_mode) |-> core_halt)
		else $error("core runs while granted");
	AST_NEED_HALT: assert property (!bus_grant_n && $past(access_needed) |-> core_halt)
		else $error("no stall on external access while granted");
	AST_GO_MODE: assert property (!bus_grant_n ##0 run_free |-> !core_halt)
		else $error("continue mode halt wrong");
	AST_RELEASE: assert property (!bus_grant_n && bus_request_n && old_revision |=> bus_grant_n && !core_halt)
		else $error("grant kept after release");
	AST_RUN_IDLE: assert property (bus_grant_n && $past(bus_grant_n) |-> !core_halt)
		else $error("halt without grant");
endmodule : ebrg_properties
bind ebrg_arbiter ebrg_properties chk_u (.*);

// ---- sim/ebrg_master.sv ----
// External master model: holds request low while want is high.
// Assumes want moves on the falling edge; the pin moves after rising edges.
`timescale 1ns/1ns
module ebrg_master (
	// Clock and command
	input wire logic clk,
	input wire logic want,
	// Request pin, idle high
	output logic     bus_request_n
);
	initial bus_request_n = 1'b1;
	always @(posedge clk) bus_request_n <= ~want;
endmodule : ebrg_master

// ---- sim/tb_external_bus_request_grant.sv ----
// Bench for the arbiter: table of grant cases, then access and boot holds.
// Assumes the master model turns want into the request pin one edge later.
`timescale 1ns/1ns
module tb_external_bus_request_grant;
	typedef struct packed {logic old; logic go; logic need; logic halt; logic [3:0] lat;} ebrg_row_type;
	// Old, continue, need, halt, cycles to grant
	ebrg_row_type rows [5] = '{8'h92, 8'hc2, 8'hf2, 8'h14, 8'h74};
	logic clk = 1'b0, rstn = 1'b0, want = 1'b0, old_revision = 1'b1, continue_mode = 1'b0;
	logic core_reset_active = 1'b0, boot_active = 1'b0, boot_byte_done = 1'b0;
	logic access_start = 1'b0, access_done = 1'b0, access_needed = 1'b0;
	logic bus_request_n, bus_grant_n, addr_oe_n, data_oe_n, core_halt;
	logic [4:0] sel_oe_n;
	int   error_cnt = 0, n_compared = 0, n;
	always #4 clk = ~clk;
	ebrg_master  master_u (.clk(clk), .want(want), .bus_request_n(bus_request_n));
	ebrg_arbiter dut_u (.*, .program_memory_select_oe_n(sel_oe_n[4]),
		.data_memory_select_oe_n(sel_oe_n[3]), .boot_memory_select_oe_n(sel_oe_n[2]),
		.read_strobe_oe_n(sel_oe_n[1]), .write_strobe_oe_n(sel_oe_n[0]));
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task give_verdict;
		$display("%0d compared, %0d wrong", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task tick(input int k); repeat (k) @(negedge clk); endtask : tick
	task automatic pulse(ref logic s); s = 1'b1; tick(1); s = 1'b0; endtask : pulse
	// Bounded wait; a hang ends the run
	task wait_grant(input logic lvl);
		n = 0;
		do begin tick(1); n++; end while (bus_grant_n !== lvl && n < 20);
		if (bus_grant_n !== lvl) begin error_cnt++; give_verdict(); end
	endtask : wait_grant
	initial begin
		tick(12);
		rstn = 1'b1;
		tick(4);
		chk({bus_grant_n, addr_oe_n, data_oe_n, sel_oe_n}, 8'h80);
		chk({7'h00, core_halt}, 8'h00);
		$display("reset case done");
		foreach (rows[i]) begin
			{old_revision, continue_mode, access_needed} = {rows[i].old, rows[i].go, rows[i].need};
			tick(1); want = 1'b1; wait_grant(1'b0);
			chk({4'h0, n[3:0]}, {4'h0, rows[i].lat});
			chk({addr_oe_n, data_oe_n, sel_oe_n, core_halt}, {7'h7f, rows[i].halt});
			want = 1'b0; wait_grant(1'b1);
			chk({4'h0, n[3:0]}, {4'h0, rows[i].lat});
			tick(3);
			chk({addr_oe_n, data_oe_n, sel_oe_n, core_halt}, 8'h00);
			$display("row %0d done", i);
		end
		// Continue mode: the core runs until it needs the bus, then stays stalled
		old_revision = 1'b1; continue_mode = 1'b1; access_needed = 1'b0; tick(1);
		want = 1'b1; wait_grant(1'b0);
		chk({7'h00, core_halt}, 8'h00);
		access_needed = 1'b1; tick(1);
		chk({7'h00, core_halt}, 8'h01);
		access_needed = 1'b0; tick(1);
		chk({7'h00, core_halt}, 8'h01);
		want = 1'b0; wait_grant(1'b1);
		chk({7'h00, core_halt}, 8'h00);
		tick(3);
		$display("continue case done");
		old_revision = 1'b1; continue_mode = 1'b0; tick(1);
		// Access first, then boot byte with the core held in reset
		for (int k = 0; k < 2; k++) begin
			core_reset_active = k[0]; boot_active = k[0];
			pulse(access_start); want = 1'b1; tick(6);
			chk({6'h00, bus_grant_n, addr_oe_n}, 8'h02);
			if (k == 0) pulse(access_done); else pulse(boot_byte_done);
			chk({7'h00, bus_grant_n}, 8'h00);
			want = 1'b0; wait_grant(1'b1); tick(3);
			$display("hold case %0d done", k);
		end
		give_verdict();
	end
endmodule : tb_external_bus_request_grant
